// ---- hw/ioevt_edge_sync.sv ----
// Two-flop synchroniser with rising-edge pulse for the asynchronous event lines.
// Assumes a single clock; the inputs come from another domain.
`timescale 1ns/1ps

module ioevt_edge_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // ************************************************************
  // Synchroniser and edge detector
  // ************************************************************
  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Pulse one cycle, two edges after the line rose
  assign rise_out = sync_r & ~prev_r;

endmodule : ioevt_edge_sync

// ---- hw/ioevt_port.sv ----
// Event-driven part of one I/O port: output latch, event actions, input sampling.
// Assumes a simple synchronous register port on ref_clk_in and asynchronous event lines.
// Summary of operation
// - Drive mode: pin follows event level, high for one, low for zero.
// - Set mode: a detected event forces the pin latch to one.
// - Clear mode: a detected event forces the pin latch to zero.
// - Toggle mode: each detected event inverts the pin latch.
// - Drive mode passes the event level combinationally, no clocked delay.
// - Set, clear, toggle act within three clocks of the event rising edge.
// - Each event input has an action field and an enable bit.
// - All enabled inputs act together for whichever events occur.
// - Each event input targets exactly one pin via its target field.
// - One pin accepts actions from up to four event inputs.
// - Simultaneous hits: all set gives set, all clear gives clear, else toggle.
// - Several drive-mode inputs on one pin: lowest event line wins.
// - A bus write to the output latch wins over event actions in the same cycle.
// - Sampled-level bit reads one for a high pin, zero for low.
// - Groups of up to 32 pins; second group registers start at 0x80.
`timescale 1ns/1ps
`include "ioevt_defines.svh"

module ioevt_port #(
  parameter int NUM_PINS = 32,
  parameter int NUM_EVENTS = 4,
  parameter logic [3:0] GROUP_INDEX = 4'h0
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire ioevt_pkg::ioevt_req_t req_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  input wire logic [NUM_EVENTS-1:0] event_in,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [31:0] group_control_out
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (NUM_PINS < 1 || NUM_PINS > 32) $error("NUM_PINS must be 1 to 32");
  if (NUM_EVENTS < 1 || NUM_EVENTS > 4) $error("NUM_EVENTS must be 1 to 4");

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0] out_latch_r;
  logic [31:0] out_latch_nxt;
  logic [31:0] event_config_reg_r;
  logic [31:0] group_control_r;
  logic [31:0] pin_meta_r;
  logic [31:0] sampled_levels_r;
  logic [NUM_EVENTS-1:0] event_rise;
  logic [31:0] pin_wide;
  logic [11:0] base;
  logic in_group;
  logic [11:0] loc;
  ioevt_pkg::ioevt_lane_t lane [NUM_EVENTS];
  logic [31:0] direct_mask;
  logic [31:0] direct_level;

  // Extract one configuration lane from the event config word
  function automatic ioevt_pkg::ioevt_lane_t get_lane(input logic [31:0] cfg, input int idx);
    get_lane = ioevt_pkg::ioevt_lane_t'(cfg[idx*`IOEVT_EVCFG_LANE_W +: `IOEVT_EVCFG_LANE_W]);
  endfunction : get_lane

  // Pin bit for a five-bit target field
  function automatic logic [31:0] pin_bit(input logic [4:0] sel);
    pin_bit = 32'h0000_0001 << sel;
  endfunction : pin_bit

  // ************************************************************
  // Address decode
  // ************************************************************
  // Each group occupies its own 0x80 window
  assign base = 12'(`IOEVT_GROUP_STRIDE * GROUP_INDEX);
  assign in_group = (req_in.addr >= base) && (req_in.addr < 12'(base + `IOEVT_GROUP_STRIDE));
  assign loc = 12'(req_in.addr - base);

  // ************************************************************
  // Event line synchroniser
  // ************************************************************
  ioevt_edge_sync #(
    .WIDTH(NUM_EVENTS)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in(event_in),
    .rise_out(event_rise)
  );

  // Unpack lanes once for all consumers
  always_comb
  begin
    for (int e = 0; e < NUM_EVENTS; e++)
    begin
      lane[e] = get_lane(event_config_reg_r, e);
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Config word: enable, action and target per event input
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      event_config_reg_r <= `IOEVT_RST_EVENT_CONFIG;
    end
    else if (req_in.wr && in_group && loc == `IOEVT_OFF_EVENT_CONFIG)
    begin
      event_config_reg_r <= req_in.wdata;
    end
  end

  // Group control: storage only, exported to the pad logic
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      group_control_r <= `IOEVT_RST_GROUP_CONTROL;
    end
    else if (req_in.wr && in_group && loc == `IOEVT_OFF_GROUP_CONTROL)
    begin
      group_control_r <= req_in.wdata;
    end
  end

  assign group_control_out = group_control_r;

  // ************************************************************
  // Clocked event actions on the output latch
  // ************************************************************
  // Resolve per pin; one action only even with up to four hits
  always_comb
  begin
    logic [2:0] hits;
    logic all_set;
    logic all_low;
    hits = 3'h0;
    all_set = 1'b1;
    all_low = 1'b1;
    out_latch_nxt = out_latch_r;
    for (int p = 0; p < 32; p++)
    begin
      hits = 3'h0;
      all_set = 1'b1;
      all_low = 1'b1;
      for (int e = 0; e < NUM_EVENTS; e++)
      begin
        // Only enabled, non-drive inputs aimed at this pin count
        if (lane[e].event_input_enable && event_rise[e] && lane[e].target_select == 5'(p)
            && lane[e].event_action_sel != ioevt_pkg::IOEVT_ACT_DRIVE)
        begin
          hits = 3'(hits + 3'h1);
          all_set = all_set && (lane[e].event_action_sel == ioevt_pkg::IOEVT_ACT_SET);
          all_low = all_low && (lane[e].event_action_sel == ioevt_pkg::IOEVT_ACT_LOW);
        end
      end
      if (hits != 3'h0)
      begin
        if (all_set)
        begin
          out_latch_nxt[p] = 1'b1;
        end
        else if (all_low)
        begin
          out_latch_nxt[p] = 1'b0;
        end
        else
        begin
          out_latch_nxt[p] = ~out_latch_r[p];
        end
      end
    end
  end

  // Bus write takes the whole latch, events in that cycle are dropped
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      out_latch_r <= `IOEVT_RST_OUT_LATCH;
    end
    else if (req_in.wr && in_group && loc == `IOEVT_OFF_OUT_LATCH)
    begin
      out_latch_r <= req_in.wdata;
    end
    else
    begin
      out_latch_r <= out_latch_nxt;
    end
  end

  // ************************************************************
  // Direct drive path
  // ************************************************************
  // Walk from highest to lowest so the lowest line ends up owning the pin
  always_comb
  begin
    direct_mask = 32'h0000_0000;
    direct_level = 32'h0000_0000;
    for (int e = NUM_EVENTS - 1; e >= 0; e--)
    begin
      if (lane[e].event_input_enable && lane[e].event_action_sel == ioevt_pkg::IOEVT_ACT_DRIVE)
      begin
        direct_mask = direct_mask | pin_bit(lane[e].target_select);
        direct_level[lane[e].target_select] = event_in[e];
      end
    end
  end

  // Unsynchronised on purpose: no latency, but glitches follow event timing
  assign pin_wide = (direct_mask & direct_level) | (~direct_mask & out_latch_r);
  assign pin_out = pin_wide[NUM_PINS-1:0];

  // ************************************************************
  // Input sampler
  // ************************************************************
  // Two stages because pins are asynchronous
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_meta_r <= 32'h0000_0000;
      sampled_levels_r <= 32'h0000_0000;
    end
    else
    begin
      pin_meta_r <= 32'(pin_in);
      sampled_levels_r <= pin_meta_r;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Registered read data; unmapped offsets read zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rdata_out <= 32'h0000_0000;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rvalid_out <= req_in.rd && in_group;
      if (!(req_in.rd && in_group))
      begin
        rdata_out <= 32'h0000_0000;
      end
      else if (loc == `IOEVT_OFF_OUT_LATCH)
      begin
        rdata_out <= out_latch_r;
      end
      else if (loc == `IOEVT_OFF_SAMPLED_LEVELS)
      begin
        rdata_out <= sampled_levels_r;
      end
      else if (loc == `IOEVT_OFF_GROUP_CONTROL)
      begin
        rdata_out <= group_control_r;
      end
      else if (loc == `IOEVT_OFF_EVENT_CONFIG)
      begin
        rdata_out <= event_config_reg_r;
      end
      else
      begin
        rdata_out <= 32'h0000_0000;
      end
    end
  end

endmodule : ioevt_port

// ---- shared/ioevt_defines.svh ----
// Constants for the event-driven I/O port: offsets, field positions, resets, timing.
// Assumes inclusion by bare name from both the package users and design files.
`ifndef IOEVT_DEFINES_SVH
`define IOEVT_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define IOEVT_GROUP_STRIDE 12'h080
`define IOEVT_OFF_OUT_LATCH 12'h010
`define IOEVT_OFF_GROUP_CONTROL 12'h024
`define IOEVT_OFF_EVENT_CONFIG 12'h02c
`define IOEVT_OFF_SAMPLED_LEVELS 12'h020

// ************************************************************
// Field layout of event_config_reg, one byte per event input
// ************************************************************
`define IOEVT_EVCFG_LANE_W 8
`define IOEVT_EVCFG_PID_LSB 0
`define IOEVT_EVCFG_ACT_LSB 5
`define IOEVT_EVCFG_EN_BIT 7

// ************************************************************
// Reset values and timing
// ************************************************************
`define IOEVT_RST_GROUP_CONTROL 32'h0000_0000
`define IOEVT_RST_EVENT_CONFIG 32'h0000_0000
`define IOEVT_RST_OUT_LATCH 32'h0000_0000
`define IOEVT_ACTION_MAX_CYCLES 3

`endif

// ---- shared/ioevt_pkg.sv ----
// Types for the event-driven I/O port.
// Assumes the defines header supplies all numeric constants.
package ioevt_pkg;

  // Event action encoding in the two-bit action field
  typedef enum logic [1:0]
  {
    IOEVT_ACT_DRIVE = 2'h0,
    IOEVT_ACT_SET = 2'h1,
    IOEVT_ACT_LOW = 2'h2,
    IOEVT_ACT_FLIP = 2'h3
  } ioevt_action_t;

  // One event input's configuration lane
  typedef struct packed
  {
    logic event_input_enable;
    ioevt_action_t event_action_sel;
    logic [4:0] target_select;
  } ioevt_lane_t;

  // Register request from the host
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ioevt_req_t;

endpackage : ioevt_pkg

// ---- verification/ioevt_port_sva.sv ----
// Checker on the event port's register answers and pins.
// Assumes it is bound into every ioevt_port instance.
`timescale 1ns/1ps
module ioevt_port_chk #(
  parameter int NUM_PINS = 32,
  parameter int NUM_EVENTS = 4,
  parameter logic [3:0] GROUP_INDEX = 4'h0
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire ioevt_pkg::ioevt_req_t req_in,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic [NUM_EVENTS-1:0] event_in,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [31:0] group_control_out
);
  // Decode; only this group's window may answer
  logic hit;
  logic gc_wr;
  assign hit = req_in.addr[11:7] == {1'b0, GROUP_INDEX};
  assign gc_wr = req_in.wr && hit && req_in.addr[6:0] == 7'h24;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  read_answer_a: assert property (req_in.rd && hit |=> rvalid_out)
    else $error("read not answered");
  no_stray_a: assert property (rvalid_out |-> $past(req_in.rd && hit))
    else $error("answer without read");
  foreign_quiet_a: assert property (req_in.rd && !hit |=> !rvalid_out && rdata_out == 32'h0)
    else $error("other group answered");
  ctrl_write_a: assert property (gc_wr |=> group_control_out == $past(req_in.wdata))
    else $error("control write lost");
  ctrl_hold_a: assert property (!gc_wr |=> $stable(group_control_out))
    else $error("control moved alone");
  ctrl_read_a: assert property (req_in.rd && hit && req_in.addr[6:0] == 7'h24
    |=> rdata_out == group_control_out) else $error("control read wrong");
  sample_read_a: assert property ($stable(pin_in) [*3] ##0 (req_in.rd && hit &&
    req_in.addr[6:0] == 7'h20) |=> rdata_out == $past(pin_in)) else $error("sampled level wrong");
  // Writes and event edges are the only causes of a pin change
  quiet_hold_a: assert property ((!req_in.wr && $stable(event_in)) [*4] |-> $stable(pin_out))
    else $error("pin moved without cause");
endmodule : ioevt_port_chk

bind ioevt_port ioevt_port_chk #(.NUM_PINS(NUM_PINS), .NUM_EVENTS(NUM_EVENTS), .GROUP_INDEX(GROUP_INDEX))
  ioevt_port_chk_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .req_in(req_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .event_in(event_in), .pin_in(pin_in), .pin_out(pin_out),
  .group_control_out(group_control_out));

// ---- verification/ioevt_router_model.sv ----
// Event router stand-in driving four event levels.
// Assumes the bench calls its tasks from one thread.
`timescale 1ns/1ps
module ioevt_router_model (
  input wire logic ref_clk_in,
  output logic [3:0] event_out
);
  // Low at reset so no false edge appears
  initial event_out = 4'h0;
  // Edge-aligned changes keep driven pins predictable
  task automatic fire(input logic [3:0] m);
    @(posedge ref_clk_in);
    event_out <= event_out | m;
    repeat (3) @(posedge ref_clk_in);
    event_out <= event_out & ~m;
  endtask : fire
  // Steady level for direct-drive lanes
  task automatic level(input logic [3:0] m);
    @(posedge ref_clk_in);
    event_out <= m;
  endtask : level
endmodule : ioevt_router_model

// ---- verification/tb_io_port_event_actions.sv ----
// Self-checking bench for the event-driven port.
// Assumes the router model and the bound checker.
`timescale 1ns/1ps
`include "ioevt_defines.svh"
module tb_io_port_event_actions;
  localparam logic [11:0] lat_a = `IOEVT_OFF_OUT_LATCH;
  localparam logic [11:0] gc_a = `IOEVT_OFF_GROUP_CONTROL;
  localparam logic [11:0] cfg_a = `IOEVT_OFF_EVENT_CONFIG;
  localparam logic [11:0] smp_a = `IOEVT_OFF_SAMPLED_LEVELS;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  ioevt_pkg::ioevt_req_t req_r = '0;
  logic [31:0] pins_r = 32'h0;
  logic [31:0] rdata;
  logic [31:0] gc;
  logic [31:0] pins;
  logic rvalid;
  logic [3:0] ev;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  ioevt_port ioevt_port_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .req_in(req_r), .rdata_out(rdata),
    .rvalid_out(rvalid), .event_in(ev), .pin_in(pins_r), .pin_out(pins), .group_control_out(gc));
  ioevt_router_model ioevt_router_model_inst (.ref_clk_in(ref_clk_in), .event_out(ev));
  // 50 MHz clock
  initial
    forever #10 ref_clk_in = ~ref_clk_in;
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    req_r <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk_in);
    req_r <= '0;
  endtask : wr
  // Answer comes one edge after the request is taken
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk_in);
    req_r <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk_in);
    req_r <= '0;
    #1;
    check({31'h0, rvalid}, {31'h0, a < 12'h080});
    check(rdata, e);
  endtask : rd
  // Latch moves by the third edge after the event rises
  task automatic act(input logic [31:0] c, input logic [3:0] m, input logic [31:0] e);
    wr(cfg_a, c);
    ioevt_router_model_inst.fire(m);
    #1;
    check(pins, e);
  endtask : act
  task automatic t_regs;
    rd(gc_a, `IOEVT_RST_GROUP_CONTROL);
    rd(cfg_a, `IOEVT_RST_EVENT_CONFIG);
    wr(gc_a, 32'ha5c3_0ff0);
    wr(`IOEVT_GROUP_STRIDE + gc_a, 32'h0000_0001);
    rd(gc_a, 32'ha5c3_0ff0);
    check(gc, 32'ha5c3_0ff0);
    rd(`IOEVT_GROUP_STRIDE + gc_a, 32'h0);
    rd(12'h030, 32'h0);
    @(posedge ref_clk_in);
    pins_r <= 32'hc3a5_0f96;
    wr(smp_a, 32'h0);
    rd(smp_a, 32'hc3a5_0f96);
  endtask : t_regs
  task automatic t_single;
    act(32'ha3, 4'h1, 32'h08);
    act(32'hc3, 4'h1, 32'h00);
    act(32'he3, 4'h1, 32'h08);
    act(32'he3, 4'h1, 32'h00);
    act(32'h63, 4'h1, 32'h00);
  endtask : t_single
  task automatic t_conflict;
    act(32'ha7a7_a7a7, 4'hf, 32'h80);
    act(32'hc7c7_c7c7, 4'hf, 32'h00);
    act(32'hc7e7_a7a7, 4'hf, 32'h80);
  endtask : t_conflict
  // Checked within the same cycle, so no clocked path can pass
  task automatic t_drive;
    wr(cfg_a, 32'h0000_8585);
    ioevt_router_model_inst.level(4'h2);
    #1 check(pins, 32'h80);
    ioevt_router_model_inst.level(4'h1);
    #1 check(pins, 32'ha0);
    ioevt_router_model_inst.level(4'h0);
    #1 check(pins, 32'h80);
  endtask : t_drive
  // Write lands on the edge where the set action would
  task automatic t_prio;
    wr(cfg_a, 32'h0000_00a3);
    fork
      ioevt_router_model_inst.fire(4'h1);
      begin
        repeat (2) @(posedge ref_clk_in);
        wr(lat_a, 32'h0000_0100);
      end
    join
    #1 check(pins, 32'h0100);
    rd(lat_a, 32'h0100);
  endtask : t_prio
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Hang guard, well above the expected run
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      finish_test;
    end
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    t_regs;
    t_single;
    t_conflict;
    t_drive;
    t_prio;
    finish_test;
  end
endmodule : tb_io_port_event_actions
